// file: logic/acsc_pkg.sv
// Constants for the serial control-two and status-one block
// Operation
// - Transmit-empty enable requests interrupt while buffer empty
// - Receive-full enable requests interrupt while data waits
// - Quiet-line enable requests interrupt while idle flag
// - Transmitter on drives output pin, loop mode releases
// - Single-wire mode: direction bit steers output pin
// - Transmitter off-then-on mid-transfer queues one idle
// - Transmitter off keeps pin until queued work ends
// - Receiver off releases input pin to port
// - Standby waits for wake condition, hardware clears
// - Break bit pulse queues break, held keeps queueing
// - Control-two readable and writable at any time
// - Status-one read-only, flags cleared by sequences
// - Buffer-empty set at reset/load, read-then-write clears
// - Done flag set when idle, read-then-action clears
// - Receive-full set on transfer, read-then-read clears
// - Idle needs full high character, start configurable
// - Idle cleared by sequence, rearmed by next character
// - Overrun when unread, new character discarded
// - Noise flag set alongside receive-full
// - Stop bit low sets framing fault
// - Parity mismatch sets parity fault when enabled
package acsc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFS_CTRL_TWO = 3'h0;
  localparam logic [2:0] OFS_STATUS_ONE = 3'h1;
  localparam logic [2:0] OFS_DATA = 3'h2;
  localparam logic [2:0] OFS_CONFIG = 3'h3;
  // Control-two fields
  localparam int C2_TX_EMPTY_IRQ_EN = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RX_FULL_IRQ_EN = 5;
  localparam int C2_QUIET_LINE_IRQ_EN = 4;
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;
  localparam int C2_RX_STANDBY = 1;
  localparam int C2_BREAK_QUEUE = 0;
  // Status-one fields
  localparam int S1_TX_EMPTY = 7;
  localparam int S1_TX_DONE = 6;
  localparam int S1_RX_FULL = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OVERRUN = 3;
  localparam int S1_NOISE = 2;
  localparam int S1_FRAME = 1;
  localparam int S1_PARITY = 0;
  localparam logic [7:0] S1_RX_MASK = 8'h3F;
  localparam logic [7:0] S1_TX_MASK = 8'hC0;
  // Configuration fields
  localparam int CF_LOOP_SELECT = 0;
  localparam int CF_RX_SOURCE_SELECT = 1;
  localparam int CF_SINGLE_WIRE_DIR = 2;
  localparam int CF_WAKE_METHOD = 3;
  localparam int CF_QUIET_COUNT_START = 4;
  localparam int CF_NINE_BIT = 5;
  localparam int CF_PARITY_ON = 6;
  localparam logic [7:0] CONFIG_MASK = 8'h7F;
  // Reset values
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  // Idle character lengths in bit times
  localparam logic [3:0] CHAR_BITS_8 = 4'hA;
  localparam logic [3:0] CHAR_BITS_9 = 4'hB;
endpackage : acsc_pkg

// file: logic/acsc_ctrl.sv
// Control-two and status-one logic of the asynchronous serial block
`timescale 1ns/1ns
module acsc_ctrl
  import acsc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [acsc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [acsc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [acsc_pkg::DATA_W-1:0] o_rd_data,
  // Transmit shifter side
  input wire logic i_tx_load,
  input wire logic i_tx_busy,
  input wire logic i_preamble_start,
  input wire logic i_break_start,
  input wire logic i_tx_serial,
  output logic [acsc_pkg::DATA_W-1:0] o_tx_data,
  output logic o_tx_data_valid,
  output logic o_tx_enable,
  output logic o_preamble_req,
  output logic o_break_req,
  // Receive shifter side
  input wire logic i_bit_tick,
  input wire logic i_rx_start,
  input wire logic i_rx_stop,
  input wire logic i_rx_char_ready,
  input wire logic [acsc_pkg::DATA_W-1:0] i_rx_data,
  input wire logic i_rx_noise,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_parity_err,
  output logic o_rx_enable,
  output logic o_rx_standby,
  output logic o_rx_serial,
  output logic o_nine_bit,
  output logic o_parity_on,
  // Pins
  input wire logic i_rxd_pin,
  input wire logic i_txd_pin_in,
  output logic o_txd_pin_out,
  output logic o_txd_pin_oe,
  output logic o_txd_owned,
  output logic o_rxd_owned,
  // Interrupt request
  output logic o_irq
);
  import acsc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic [7:0] status;
    logic [7:0] seen;
    logic preamble_pend;
    logic break_pend;
    logic [3:0] idle_cnt;
    logic idle_arm;
    logic idle_allow;
    logic [7:0] rd_data;
    logic rxd_s1;
    logic rxd_s2;
    logic txi_s1;
    logic txi_s2;
  } acsc_state_t;

  acsc_state_t state_reg;
  acsc_state_t state_next;

  logic wr_ctrl;
  logic wr_cfg;
  logic wr_data;
  logic rd_stat;
  logic rd_data;
  logic te_rise;
  logic sbk_rise;
  logic sbk_wr1;
  logic loop_mode;
  logic single_wire;
  logic rx_line;
  logic idle_hit;
  logic wake_hit;
  logic accept;
  logic [3:0] char_bits;

  // Address match for one strobe
  function automatic logic hit(input logic strobe,
                               input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] ofs);
  begin
    hit = strobe && (addr == ofs);
  end
  endfunction : hit

  always_comb
  begin
    state_next = state_reg;
    state_next.rd_data = 8'h00;
    state_next.rxd_s1 = i_rxd_pin;
    state_next.rxd_s2 = state_reg.rxd_s1;
    state_next.txi_s1 = i_txd_pin_in;
    state_next.txi_s2 = state_reg.txi_s1;

    wr_ctrl = hit(i_wr, i_addr, OFS_CTRL_TWO);
    wr_cfg = hit(i_wr, i_addr, OFS_CONFIG);
    wr_data = hit(i_wr, i_addr, OFS_DATA);
    rd_stat = hit(i_rd, i_addr, OFS_STATUS_ONE);
    rd_data = hit(i_rd, i_addr, OFS_DATA);

    loop_mode = state_reg.cfg[CF_LOOP_SELECT];
    single_wire = loop_mode && state_reg.cfg[CF_RX_SOURCE_SELECT];
    // Loopback feeds the receiver from the transmitter internally, single-wire from the TXD pin
    if (single_wire)
    begin
      rx_line = state_reg.txi_s2;
    end
    else if (loop_mode)
    begin
      rx_line = i_tx_serial;
    end
    else
    begin
      rx_line = state_reg.rxd_s2;
    end

    te_rise = wr_ctrl && !state_reg.ctrl[C2_TX_ON] &&
              i_wr_data[C2_TX_ON];
    sbk_rise = wr_ctrl && !state_reg.ctrl[C2_BREAK_QUEUE] &&
               i_wr_data[C2_BREAK_QUEUE];
    sbk_wr1 = wr_ctrl && i_wr_data[C2_BREAK_QUEUE];

    // Register reads, answered one cycle later
    if (rd_stat)
    begin
      state_next.rd_data = state_reg.status;
      state_next.seen = state_reg.seen | state_reg.status;
    end
    else if (hit(i_rd, i_addr, OFS_CTRL_TWO))
    begin
      state_next.rd_data = state_reg.ctrl;
    end
    else if (rd_data)
    begin
      state_next.rd_data = state_reg.rx_buf;
    end
    else if (hit(i_rd, i_addr, OFS_CONFIG))
    begin
      state_next.rd_data = state_reg.cfg;
    end

    // Control writes accepted in any state
    if (wr_ctrl)
    begin
      state_next.ctrl = i_wr_data;
    end
    if (wr_cfg)
    begin
      state_next.cfg = i_wr_data & CONFIG_MASK;
    end

    // Queued preamble and break, set wins over the taking pulse
    if (i_preamble_start)
    begin
      state_next.preamble_pend = 1'b0;
    end
    if (te_rise)
    begin
      state_next.preamble_pend = 1'b1;
    end
    if (i_break_start)
    begin
      state_next.break_pend = 1'b0;
    end
    if (sbk_rise)
    begin
      state_next.break_pend = 1'b1;
    end

    // Idle line timing on bit ticks
    char_bits = state_reg.cfg[CF_NINE_BIT] ? CHAR_BITS_9 : CHAR_BITS_8;
    idle_hit = i_bit_tick && state_reg.idle_arm && rx_line &&
               (state_reg.idle_cnt + 4'h1 == char_bits);
    if (state_reg.cfg[CF_QUIET_COUNT_START] ? i_rx_stop : i_rx_start)
    begin
      state_next.idle_cnt = 4'h0;
      state_next.idle_arm = 1'b1;
    end
    else if (i_bit_tick && state_reg.idle_arm)
    begin
      if (!rx_line)
      begin
        state_next.idle_cnt = 4'h0;
      end
      else if (idle_hit)
      begin
        state_next.idle_cnt = 4'h0;
        state_next.idle_arm = 1'b0;
      end
      else
      begin
        state_next.idle_cnt = state_reg.idle_cnt + 4'h1;
      end
    end

    // Standby wakeup; a software write in the same cycle wins
    wake_hit = state_reg.cfg[CF_WAKE_METHOD] ?
               (i_rx_char_ready && i_rx_data[DATA_W-1]) : idle_hit;
    if (state_reg.ctrl[C2_RX_STANDBY] && wake_hit && !wr_ctrl)
    begin
      state_next.ctrl[C2_RX_STANDBY] = 1'b0;
    end

    // Transmit buffer
    if (wr_data)
    begin
      state_next.tx_buf = i_wr_data;
      state_next.seen[S1_TX_EMPTY] = 1'b0;
      if (state_reg.seen[S1_TX_EMPTY])
      begin
        state_next.status[S1_TX_EMPTY] = 1'b0;
      end
    end
    if (i_tx_load)
    begin
      state_next.status[S1_TX_EMPTY] = 1'b1;
    end

    // Transmission complete
    if (wr_data || te_rise || sbk_wr1)
    begin
      state_next.seen[S1_TX_DONE] = 1'b0;
      if (state_reg.seen[S1_TX_DONE])
      begin
        state_next.status[S1_TX_DONE] = 1'b0;
      end
    end
    if (state_next.status[S1_TX_EMPTY] && !i_tx_busy &&
        !state_next.preamble_pend && !state_next.break_pend &&
        !state_next.ctrl[C2_BREAK_QUEUE])
    begin
      state_next.status[S1_TX_DONE] = 1'b1;
    end

    // Receive flags cleared by status read then data read
    if (rd_data)
    begin
      state_next.status = state_next.status &
                          ~(state_reg.seen & S1_RX_MASK);
      state_next.seen = state_next.seen & ~S1_RX_MASK;
    end

    // New character; standby drops all but a waking address mark
    accept = i_rx_char_ready &&
             (!state_reg.ctrl[C2_RX_STANDBY] ||
              (state_reg.cfg[CF_WAKE_METHOD] && i_rx_data[DATA_W-1]));
    if (accept)
    begin
      if (state_reg.status[S1_RX_FULL])
      begin
        // Unread data kept, newcomer and its errors lost
        state_next.status[S1_OVERRUN] = 1'b1;
      end
      else
      begin
        state_next.rx_buf = i_rx_data;
        state_next.status[S1_RX_FULL] = 1'b1;
        state_next.status[S1_NOISE] = i_rx_noise;
        state_next.status[S1_FRAME] = i_rx_frame_err;
        state_next.status[S1_PARITY] = i_rx_parity_err &&
                                       state_reg.cfg[CF_PARITY_ON];
        state_next.idle_allow = 1'b1;
      end
    end

    // Idle reported once per burst of traffic
    if (idle_hit && state_reg.idle_allow)
    begin
      state_next.status[S1_IDLE] = 1'b1;
      state_next.idle_allow = 1'b0;
    end

    if (i_rst)
    begin
      state_next = '0;
      state_next.ctrl = CTRL_TWO_RST;
      state_next.cfg = CONFIG_RST;
      state_next.status = S1_TX_MASK;
      state_next.rxd_s1 = 1'b1;
      state_next.rxd_s2 = 1'b1;
      state_next.txi_s1 = 1'b1;
      state_next.txi_s2 = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_reg <= state_next;
  end

  // Register-facing outputs
  assign o_rd_data = state_reg.rd_data;
  assign o_tx_data = state_reg.tx_buf;
  assign o_tx_data_valid = !state_reg.status[S1_TX_EMPTY];
  assign o_tx_enable = state_reg.ctrl[C2_TX_ON];
  assign o_preamble_req = state_reg.preamble_pend;
  assign o_break_req = state_reg.break_pend ||
                       state_reg.ctrl[C2_BREAK_QUEUE];
  assign o_rx_enable = state_reg.ctrl[C2_RX_ON];
  assign o_rx_standby = state_reg.ctrl[C2_RX_STANDBY];
  assign o_rx_serial = rx_line;
  assign o_nine_bit = state_reg.cfg[CF_NINE_BIT];
  assign o_parity_on = state_reg.cfg[CF_PARITY_ON];

  // Pin ownership outlasts the enable until queued work drains
  assign o_txd_owned = (state_reg.ctrl[C2_TX_ON] || i_tx_busy ||
                        state_reg.preamble_pend || state_reg.break_pend ||
                        !state_reg.status[S1_TX_EMPTY]) &&
                       !(loop_mode && !state_reg.cfg[CF_RX_SOURCE_SELECT]);
  assign o_txd_pin_oe = o_txd_owned &&
                        (!single_wire ||
                         state_reg.cfg[CF_SINGLE_WIRE_DIR]);
  assign o_txd_pin_out = i_tx_serial;
  assign o_rxd_owned = state_reg.ctrl[C2_RX_ON];

  // Level request, held while any enabled flag stands
  assign o_irq =
    (state_reg.ctrl[C2_TX_EMPTY_IRQ_EN] &&
     state_reg.status[S1_TX_EMPTY]) ||
    (state_reg.ctrl[C2_TX_DONE_IRQ_EN] &&
     state_reg.status[S1_TX_DONE]) ||
    (state_reg.ctrl[C2_RX_FULL_IRQ_EN] &&
     state_reg.status[S1_RX_FULL]) ||
    (state_reg.ctrl[C2_QUIET_LINE_IRQ_EN] &&
     state_reg.status[S1_IDLE]);
endmodule : acsc_ctrl

// file: verif/acsc_ctrl_props.sv
// Checker for the control-two and status-one block
`timescale 1ns/1ns
module acsc_ctrl_props
  import acsc_pkg::*;
(
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [acsc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [acsc_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [acsc_pkg::DATA_W-1:0] o_rd_data,
  // Shifter side, pins and interrupt
  input wire logic i_tx_load,
  input wire logic i_tx_busy,
  input wire logic [acsc_pkg::DATA_W-1:0] o_tx_data,
  input wire logic o_tx_data_valid,
  input wire logic o_break_req,
  input wire logic o_rx_standby,
  input wire logic o_txd_pin_oe,
  input wire logic o_txd_owned,
  input wire logic o_irq
);
  logic [3:0] ctl_reg;
  logic [1:0] cfg_reg;
  logic wr_ctl;
  assign wr_ctl = i_wr && i_addr == OFS_CTRL_TWO;
  // Enable and loop bits only: hardware never changes them
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ctl_reg <= 4'h0;
      cfg_reg <= 2'h0;
    end
    else
    begin
      if (wr_ctl)
        ctl_reg <= i_wr_data[7:4];
      if (i_wr && i_addr == OFS_CONFIG)
        cfg_reg <= i_wr_data[1:0];
    end
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  rd_idle_zero_a: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data outside read");
  irq_empty_a: assert property (ctl_reg[3] && !o_tx_data_valid |-> o_irq)
    else $error("missing empty irq");
  load_empty_a: assert property (i_tx_load |=> !o_tx_data_valid)
    else $error("load left buffer full");
  data_take_a: assert property (i_wr && i_addr == OFS_DATA |=>
    o_tx_data == $past(i_wr_data))
    else $error("buffer not written");
  break_req_a: assert property (wr_ctl && i_wr_data[0] |-> ##[1:2] o_break_req)
    else $error("break not requested");
  standby_wr_a: assert property (wr_ctl |=> o_rx_standby == $past(i_wr_data[1]))
    else $error("standby write lost");
  busy_owns_a: assert property (i_tx_busy && cfg_reg != 2'h1 |-> o_txd_owned)
    else $error("pin released while busy");
  loop_free_a: assert property (cfg_reg == 2'h1 |-> !o_txd_owned)
    else $error("pin kept in loop mode");
  oe_owned_a: assert property (o_txd_pin_oe |-> o_txd_owned)
    else $error("pin driven unowned");
  cover property (i_tx_load);
  cover property (i_tx_busy && o_txd_owned);
  cover property (o_irq && ctl_reg[0]);
endmodule : acsc_ctrl_props
bind acsc_ctrl acsc_ctrl_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
  .o_rd_data(o_rd_data), .i_tx_load(i_tx_load), .i_tx_busy(i_tx_busy),
  .o_tx_data(o_tx_data), .o_tx_data_valid(o_tx_data_valid),
  .o_break_req(o_break_req), .o_rx_standby(o_rx_standby),
  .o_txd_pin_oe(o_txd_pin_oe), .o_txd_owned(o_txd_owned), .o_irq(o_irq));

// file: verif/acsc_remote.sv
// Remote sender as seen through the receive shifter
`timescale 1ns/1ns
module acsc_remote (
  // Bench control
  input wire logic i_clk,
  input wire logic i_send,
  input wire logic [7:0] i_data,
  input wire logic [2:0] i_err,
  // Receive shifter events
  output logic o_rx_start,
  output logic o_rx_stop,
  output logic o_char_ready,
  output logic [7:0] o_rx_data,
  output logic [2:0] o_flags
);
  logic [2:0] ph_reg = 3'h0;
  always @(posedge i_clk)
    ph_reg <= {ph_reg[1:0], i_send};
  assign o_rx_start = ph_reg[0];
  assign o_char_ready = ph_reg[1];
  assign o_rx_stop = ph_reg[2];
  // Data only valid beside ready; inverted otherwise
  assign o_rx_data = ph_reg[1] ? i_data : ~i_data;
  assign o_flags = ph_reg[1] ? i_err : 3'h0;
endmodule : acsc_remote

// file: verif/test_async_serial_control_status.sv
// Self-checking bench for the control-two and status-one block
`timescale 1ns/1ns
module test_async_serial_control_status;
  import acsc_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, busy, send, stp, st, rdy;
  logic [2:0] i_addr, err, fl;
  logic [7:0] i_wr_data, o_rd_data, o_tx_data, sd, rxd;
  logic [3:0] ev;
  logic o_tx_data_valid, o_break_req, o_rx_standby, o_irq, oe, own;
  logic tx_en, pre_req, rx_en, rx_ser, nine, par, pin_out, rxd_own, txs;
  int mismatches = 0;
  int checks_done = 0;
  logic [18:0] rows [6] = '{19'h0A5A5, 19'h05A5A, 19'h3FF7F, 19'h5FF00,
    19'h30000, 19'h00000};
  acsc_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_tx_load(ev[0]), .i_tx_busy(busy), .i_preamble_start(ev[1]),
    .i_break_start(ev[2]), .i_tx_serial(txs), .o_tx_data(o_tx_data),
    .o_tx_data_valid(o_tx_data_valid), .o_tx_enable(tx_en),
    .o_preamble_req(pre_req),
    .o_break_req(o_break_req), .i_bit_tick(ev[3]), .i_rx_start(st),
    .i_rx_stop(stp), .i_rx_char_ready(rdy), .i_rx_data(rxd),
    .i_rx_noise(fl[2]), .i_rx_frame_err(fl[1]), .i_rx_parity_err(fl[0]),
    .o_rx_enable(rx_en), .o_rx_standby(o_rx_standby), .o_rx_serial(rx_ser),
    .o_nine_bit(nine), .o_parity_on(par), .i_rxd_pin(1'b1),
    .i_txd_pin_in(1'b1), .o_txd_pin_out(pin_out), .o_txd_pin_oe(oe),
    .o_txd_owned(own), .o_rxd_owned(rxd_own), .o_irq(o_irq));
  acsc_remote far (.i_clk(i_clk), .i_send(send), .i_data(sd), .i_err(err),
    .o_rx_start(st), .o_rx_stop(stp), .o_char_ready(rdy), .o_rx_data(rxd),
    .o_flags(fl));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rd_data, e);
  endtask : rd
  task automatic pulse(input logic [3:0] v, input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      ev <= v;
      @(posedge i_clk);
      ev <= 4'h0;
    end
  endtask : pulse
  // Bounded wait: a stuck sender ends the run
  task automatic put(input logic [7:0] d, input logic [2:0] e);
    int n;
    @(posedge i_clk);
    send <= 1'b1;
    sd <= d;
    err <= e;
    @(posedge i_clk);
    send <= 1'b0;
    n = 0;
    while (!stp && n < 8)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    if (!stp)
    begin
      mismatches++;
      results();
    end
  endtask : put
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    {i_rst, i_wr, i_rd, busy, send} = 5'h10;
    txs = 1'b1;
    {i_addr, i_wr_data, sd, err, ev} = '0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(OFS_CTRL_TWO, CTRL_TWO_RST);
    rd(OFS_STATUS_ONE, 8'hC0);
    foreach (rows[i])
    begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], rows[i][7:0]);
    end
    pulse(4'h6, 1);
    wr(OFS_STATUS_ONE, 8'h00);
    rd(OFS_STATUS_ONE, 8'hC0);
    wr(OFS_CTRL_TWO, 8'h80);
    #1 chk(o_irq, 1'b1);
    wr(OFS_CTRL_TWO, 8'h40);
    #1 chk(o_irq, 1'b1);
    wr(OFS_CTRL_TWO, 8'h30);
    #1 chk(o_irq, 1'b0);
    wr(OFS_CTRL_TWO, 8'h04);
    #1 chk({rx_en, rxd_own}, 8'h03);
    rd(OFS_STATUS_ONE, 8'hC0);
    wr(OFS_DATA, 8'h3C);
    #1 chk({o_tx_data_valid, o_tx_data[6:0]}, 8'hBC);
    rd(OFS_STATUS_ONE, 8'h00);
    busy <= 1'b1;
    pulse(4'h1, 1);
    rd(OFS_STATUS_ONE, 8'h80);
    busy <= 1'b0;
    rd(OFS_STATUS_ONE, 8'hC0);
    wr(OFS_CTRL_TWO, 8'h01);
    wr(OFS_CTRL_TWO, 8'h00);
    #1 chk(o_break_req, 1'b1);
    chk({rx_en, rxd_own}, 8'h00);
    pulse(4'h4, 1);
    @(posedge i_clk);
    #1 chk(o_break_req, 1'b0);
    wr(OFS_CTRL_TWO, 8'h08);
    #1 chk({tx_en, pre_req}, 8'h03);
    pulse(4'h2, 1);
    #1 chk(pre_req, 1'b0);
    busy <= 1'b1;
    wr(OFS_CTRL_TWO, 8'h00);
    #1 chk({own, oe}, 2'h3);
    busy <= 1'b0;
    @(posedge i_clk);
    #1 chk(own, 1'b0);
    wr(OFS_CONFIG, 8'h01);
    wr(OFS_CTRL_TWO, 8'h08);
    #1 chk(own, 1'b0);
    txs <= 1'b0;
    #1 chk({pin_out, rx_ser}, 8'h00);
    txs <= 1'b1;
    #1 chk({pin_out, rx_ser}, 8'h03);
    wr(OFS_CONFIG, 8'h03);
    #1 chk({own, oe}, 2'h2);
    wr(OFS_CONFIG, 8'h07);
    #1 chk({own, oe}, 2'h3);
    wr(OFS_CTRL_TWO, 8'h00);
    pulse(4'h2, 1);
    wr(OFS_CONFIG, 8'h00);
    put(8'h81, 3'h0);
    put(8'h42, 3'h0);
    wr(OFS_CTRL_TWO, 8'h20);
    #1 chk(o_irq, 1'b1);
    rd(OFS_STATUS_ONE, 8'hE8);
    rd(OFS_DATA, 8'h81);
    rd(OFS_STATUS_ONE, 8'hC0);
    wr(OFS_CONFIG, 8'h60);
    #1 chk({nine, par}, 8'h03);
    put(8'h55, 3'h7);
    rd(OFS_STATUS_ONE, 8'hE7);
    rd(OFS_DATA, 8'h55);
    wr(OFS_CTRL_TWO, 8'h10);
    pulse(4'h8, 10);
    rd(OFS_STATUS_ONE, 8'hC0);
    pulse(4'h8, 1);
    #1 chk(o_irq, 1'b1);
    rd(OFS_STATUS_ONE, 8'hD0);
    rd(OFS_DATA, 8'h55);
    pulse(4'h8, 12);
    rd(OFS_STATUS_ONE, 8'hC0);
    wr(OFS_CONFIG, 8'h00);
    wr(OFS_CTRL_TWO, 8'h02);
    put(8'h11, 3'h0);
    pulse(4'h8, 10);
    #1 chk(o_rx_standby, 1'b0);
    results();
  end
endmodule : test_async_serial_control_status
